// [design/pmc_pkg.sv]
// package of offsets, fields, reset values and codes for the misc config registers
package pmc_pkg;
  // register offsets (word addresses on the management port)
  localparam logic [15:0] OFS_LINE_DRIVER   = 16'h0404;
  localparam logic [15:0] OFS_RX_GAIN       = 16'h040D;
  localparam logic [15:0] OFS_GENERAL       = 16'h0456;
  localparam logic [15:0] OFS_INDICATOR     = 16'h0460;
  localparam logic [15:0] OFS_IO_CONTROL    = 16'h0461;
  localparam logic [15:0] OFS_STRAP_STATUS  = 16'h0467;
  localparam logic [15:0] OFS_BASIC_STATUS  = 16'h0001;
  // reset values
  localparam logic [15:0] RST_LINE_DRIVER   = 16'h0080;
  localparam logic [15:0] RST_RX_GAIN       = 16'h0000;
  localparam logic [15:0] RST_GENERAL       = 16'h0008;
  localparam logic [15:0] RST_INDICATOR     = 16'h5665;
  localparam logic [15:0] RST_IO_CONTROL    = 16'h0010;
  localparam logic [15:0] RST_STRAP_STATUS  = 16'h0000;
  // field positions
  localparam int GAIN_LSB       = 0;
  localparam int GAIN_W         = 5;
  localparam int SHORT_GAP_BIT  = 3;
  localparam int FIRST_SRC_LSB  = 12;
  localparam int SECOND_SRC_LSB = 8;
  localparam int THIRD_SRC_LSB  = 4;
  localparam int SRC_W          = 4;
  localparam int SLEW_BIT       = 0;
  // gain levels in millivolts
  localparam int GAIN_BASE_MV   = 200;
  localparam int GAIN_STEP_MV   = 25;
  localparam int GAIN_MAX_MV    = 575;
  // inter-packet gap times and cycle counts at 20 MHz
  localparam int CLK_PERIOD_NS  = 50;
  localparam int GAP_SHORT_NS   = 120;
  localparam int GAP_LONG_NS    = 200;
  localparam logic [7:0] GAP_SHORT_CYC = 8'((GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_LONG_CYC  = 8'((GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // indicator source codes
  typedef enum logic [3:0] {
    SRC_LINK       = 4'h0,
    SRC_ACTIVITY   = 4'h1,
    SRC_TX_ACT     = 4'h2,
    SRC_RX_ACT     = 4'h3,
    SRC_COLLISION  = 4'h4,
    SRC_SPEED_100  = 4'h5,
    SRC_SPEED_10   = 4'h6,
    SRC_FULL_DUP   = 4'h7,
    SRC_LINK_BLINK = 4'h8,
    SRC_STRETCH    = 4'h9,
    SRC_LINK_100FD = 4'hA,
    SRC_LOW_POWER  = 4'hB,
    SRC_MII_ERROR  = 4'hC,
    SRC_LINK_LOST  = 4'hD,
    SRC_PRBS_ERROR = 4'hE,
    SRC_RESERVED   = 4'hF
  } pmc_src_type;
endpackage : pmc_pkg

// [design/pmc_misc_config_regs.sv]
// misc configuration registers with indicator source selection
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module pmc_misc_config_regs
  import pmc_pkg::*;
#(
  parameter int NUM_IND   = 3,   // indicator outputs
  parameter int BLINK_DIV = 20   // blink and stretch half period in cycles
) (
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // management register port
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // status sources
  input  wire logic        link_up_in,
  input  wire logic        tx_act_in,
  input  wire logic        rx_act_in,
  input  wire logic        collision_in,
  input  wire logic        speed_100_in,
  input  wire logic        full_duplex_in,
  input  wire logic        low_power_in,
  input  wire logic        mii_error_in,
  input  wire logic        prbs_error_in,
  input  wire logic        prbs_clear_in,
  input  wire logic [10:0] strap_in,
  // settings to the rest of the PHY
  output logic [4:0]       tenbase_rx_gain_code_out,
  output logic [9:0]       tenbase_rx_gain_mv_out,
  output logic             short_gap_select_out,
  output logic [7:0]       gap_cycles_out,
  output logic             host_io_slew_select_out,
  output logic [15:0]      line_driver_prog_out,
  output logic [NUM_IND-1:0] indicator_out
);

  // only the three documented indicator fields exist
  initial begin
    if (NUM_IND != 3 || BLINK_DIV < 1 || BLINK_DIV > 65535) begin
      $error("pmc_misc_config_regs: unsupported parameters");
    end
  end

  // register state
  logic [15:0] line_driver_prog_reserved, next_line_driver_prog_reserved;
  logic [15:0] rx_tenbase_gain_ctrl,      next_rx_tenbase_gain_ctrl;
  logic [15:0] general_config,            next_general_config;
  logic [15:0] indicator_config,          next_indicator_config;
  logic [15:0] io_control,                next_io_control;
  logic [15:0] strap_latch_status,        next_strap_latch_status;
  logic        strap_taken,               next_strap_taken;
  logic [15:0] rdata,                     next_rdata;
  // indicator helpers
  logic [15:0] blink_cnt,                 next_blink_cnt;
  logic        blink_phase,               next_blink_phase;
  logic [15:0] stretch_cnt,               next_stretch_cnt;
  logic        link_prev,                 next_link_prev;
  logic        link_lost,                 next_link_lost;
  logic        prbs_seen,                 next_prbs_seen;
  logic [NUM_IND-1:0] ind,                next_ind;
  // derived settings
  logic [4:0]  gain_code;
  logic [9:0]  gain_mv;
  logic [7:0]  gap_cyc;

  // register write and read decode
  always_comb begin
    next_line_driver_prog_reserved = line_driver_prog_reserved;
    next_rx_tenbase_gain_ctrl      = rx_tenbase_gain_ctrl;
    next_general_config            = general_config;
    next_indicator_config          = indicator_config;
    next_io_control                = io_control;
    next_strap_latch_status        = strap_latch_status;
    next_strap_taken               = 1'b1;
    next_rdata                     = 16'h0000;
    // strap levels caught on the first enabled cycle after reset release
    if (!strap_taken) begin
      next_strap_latch_status = {5'h00, strap_in};
    end
    if (wr_in) begin
      case (addr_in)
        OFS_LINE_DRIVER: next_line_driver_prog_reserved = wdata_in;
        OFS_RX_GAIN:     next_rx_tenbase_gain_ctrl      = wdata_in;
        OFS_GENERAL:     next_general_config            = wdata_in;
        OFS_INDICATOR:   next_indicator_config          = wdata_in;
        OFS_IO_CONTROL:  next_io_control                = wdata_in;
        default:         next_rdata                     = 16'h0000;  // strap and others ignore
      endcase
    end
    if (rd_in) begin
      // full word back, reserved bits included
      case (addr_in)
        OFS_LINE_DRIVER:  next_rdata = line_driver_prog_reserved;
        OFS_RX_GAIN:      next_rdata = rx_tenbase_gain_ctrl;
        OFS_GENERAL:      next_rdata = general_config;
        OFS_INDICATOR:    next_rdata = indicator_config;
        OFS_IO_CONTROL:   next_rdata = io_control;
        OFS_STRAP_STATUS: next_rdata = strap_latch_status;
        default:          next_rdata = 16'h0000;  // unmapped reads as zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_driver_prog_reserved <= RST_LINE_DRIVER;
      rx_tenbase_gain_ctrl      <= RST_RX_GAIN;
      general_config            <= RST_GENERAL;
      indicator_config          <= RST_INDICATOR;
      io_control                <= RST_IO_CONTROL;
      strap_latch_status        <= RST_STRAP_STATUS;
      strap_taken               <= 1'b0;
      rdata                     <= 16'h0000;
    end else if (clk_en_in) begin
      line_driver_prog_reserved <= next_line_driver_prog_reserved;
      rx_tenbase_gain_ctrl      <= next_rx_tenbase_gain_ctrl;
      general_config            <= next_general_config;
      indicator_config          <= next_indicator_config;
      io_control                <= next_io_control;
      strap_latch_status        <= next_strap_latch_status;
      strap_taken               <= next_strap_taken;
      rdata                     <= next_rdata;
    end
  end

  // settings decoded from the registers
  always_comb begin
    gain_code = rx_tenbase_gain_ctrl[GAIN_LSB +: GAIN_W];
    // codes past the top level are clamped to the top level
    if (gain_code > 5'((GAIN_MAX_MV - GAIN_BASE_MV) / GAIN_STEP_MV)) begin
      gain_mv = 10'(GAIN_MAX_MV);
    end else begin
      gain_mv = 10'(GAIN_BASE_MV) + 10'(GAIN_STEP_MV) * 10'(gain_code);
    end
    // shorter gap only when the select bit is set
    gap_cyc = general_config[SHORT_GAP_BIT] ? GAP_SHORT_CYC : GAP_LONG_CYC;
  end

  // indicator sources, one selector per output
  always_comb begin
    next_blink_cnt   = blink_cnt;
    next_blink_phase = blink_phase;
    next_stretch_cnt = stretch_cnt;
    next_link_prev   = link_up_in;
    next_link_lost   = link_lost;
    next_prbs_seen   = prbs_seen;
    next_ind         = ind;
    // free-running blink timebase
    if (blink_cnt == 16'(BLINK_DIV - 1)) begin
      next_blink_cnt   = 16'h0000;
      next_blink_phase = !blink_phase;
    end else begin
      next_blink_cnt = blink_cnt + 16'h0001;
    end
    // activity pulses stretched so they stay visible
    if (tx_act_in || rx_act_in) begin
      next_stretch_cnt = 16'(BLINK_DIV);
    end else if (stretch_cnt != 16'h0000) begin
      next_stretch_cnt = stretch_cnt - 16'h0001;
    end
    // read of basic status clears the loss latch; a new loss wins
    if (rd_in && addr_in == OFS_BASIC_STATUS) begin
      next_link_lost = 1'b0;
    end
    if (link_prev && !link_up_in) begin
      next_link_lost = 1'b1;
    end
    // error counter clear releases the latch; a new error wins
    if (prbs_clear_in) begin
      next_prbs_seen = 1'b0;
    end
    if (prbs_error_in) begin
      next_prbs_seen = 1'b1;
    end
    for (int i = 0; i < NUM_IND; i++) begin
      case (indicator_config[FIRST_SRC_LSB - SRC_W * i +: SRC_W])
        SRC_LINK:       next_ind[i] = link_up_in;
        SRC_ACTIVITY:   next_ind[i] = tx_act_in || rx_act_in;
        SRC_TX_ACT:     next_ind[i] = tx_act_in;
        SRC_RX_ACT:     next_ind[i] = rx_act_in;
        SRC_COLLISION:  next_ind[i] = collision_in;
        SRC_SPEED_100:  next_ind[i] = speed_100_in;
        SRC_SPEED_10:   next_ind[i] = !speed_100_in;
        SRC_FULL_DUP:   next_ind[i] = full_duplex_in;
        SRC_LINK_BLINK: next_ind[i] = link_up_in &&
                                      !(stretch_cnt != 16'h0000 && blink_phase);
        SRC_STRETCH:    next_ind[i] = stretch_cnt != 16'h0000;
        SRC_LINK_100FD: next_ind[i] = link_up_in && speed_100_in && full_duplex_in;
        SRC_LOW_POWER:  next_ind[i] = low_power_in;
        SRC_MII_ERROR:  next_ind[i] = mii_error_in;
        SRC_LINK_LOST:  next_ind[i] = link_lost;
        SRC_PRBS_ERROR: next_ind[i] = prbs_seen;
        default:        next_ind[i] = 1'b0;  // reserved code keeps the output off
      endcase
    end
  end

  // indicator flops
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      blink_cnt   <= 16'h0000;
      blink_phase <= 1'b0;
      stretch_cnt <= 16'h0000;
      link_prev   <= 1'b0;
      link_lost   <= 1'b0;
      prbs_seen   <= 1'b0;
      ind         <= '0;
    end else if (clk_en_in) begin
      blink_cnt   <= next_blink_cnt;
      blink_phase <= next_blink_phase;
      stretch_cnt <= next_stretch_cnt;
      link_prev   <= next_link_prev;
      link_lost   <= next_link_lost;
      prbs_seen   <= next_prbs_seen;
      ind         <= next_ind;
    end
  end

  // registered copies of the settings so every output is a flop
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tenbase_rx_gain_code_out <= RST_RX_GAIN[GAIN_LSB +: GAIN_W];
      tenbase_rx_gain_mv_out   <= 10'(GAIN_BASE_MV);
      short_gap_select_out     <= RST_GENERAL[SHORT_GAP_BIT];
      gap_cycles_out           <= GAP_SHORT_CYC;
      host_io_slew_select_out  <= RST_IO_CONTROL[SLEW_BIT];
      line_driver_prog_out     <= RST_LINE_DRIVER;
    end else if (clk_en_in) begin
      tenbase_rx_gain_code_out <= gain_code;
      tenbase_rx_gain_mv_out   <= gain_mv;
      short_gap_select_out     <= general_config[SHORT_GAP_BIT];
      gap_cycles_out           <= gap_cyc;
      host_io_slew_select_out  <= io_control[SLEW_BIT];
      line_driver_prog_out     <= line_driver_prog_reserved;
    end
  end

  assign rdata_out     = rdata;
  assign indicator_out = ind;

endmodule : pmc_misc_config_regs

// [verif/pmc_regs_asserts.sv]
// checker of gain, gap and indicator source settings for the misc config registers
`timescale 1ns/1ns
module pmc_regs_asserts
  import pmc_pkg::*;
(
  // clock, reset, register port
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic        clk_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  // status sources
  input wire logic        link_up_in,
  input wire logic        collision_in,
  input wire logic        speed_100_in,
  input wire logic        prbs_error_in,
  // settings out
  input wire logic [4:0]  tenbase_rx_gain_code_out,
  input wire logic [9:0]  tenbase_rx_gain_mv_out,
  input wire logic        short_gap_select_out,
  input wire logic [7:0]  gap_cycles_out,
  input wire logic [2:0]  indicator_out
);
  logic [15:0] sel;    // shadow of the selection word
  logic        rd_clr; // read of the basic status word
  logic [9:0]  mv_exp; // level the gain code should give
  assign rd_clr = rd_in && addr_in == OFS_BASIC_STATUS;
  assign mv_exp = tenbase_rx_gain_code_out > 5'h0F ? 10'h23F
                  : 10'h0C8 + 10'h019 * 10'(tenbase_rx_gain_code_out);
  // shadow follows accepted writes, so bodies stay unseen
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) sel <= RST_INDICATOR;
    else if (clk_en_in && wr_in && addr_in == OFS_INDICATOR) sel <= wdata_in;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_gain_level_map: assert property (tenbase_rx_gain_mv_out == mv_exp)
    else $error("gain level wrong");
  a_gap_from_select: assert property (gap_cycles_out == (short_gap_select_out ? 8'h03 : 8'h04))
    else $error("gap length wrong");
  a_first_link_src: assert property ($past(sel[15:12]) == 4'h0 |-> indicator_out[0] == $past(link_up_in))
    else $error("first indicator wrong");
  a_second_coll_src: assert property ($past(sel[11:8]) == 4'h4 |-> indicator_out[1] == $past(collision_in))
    else $error("second indicator wrong");
  a_third_speed_src: assert property (!$past(reset_in) && $past(sel[7:4]) == 4'h6 |-> indicator_out[2] == !$past(speed_100_in))
    else $error("third indicator wrong");
  a_lost_latch_set: assert property ($past(link_up_in) && !link_up_in ##1 sel[15:12] == 4'hD |=> indicator_out[0])
    else $error("link loss not latched");
  a_lost_read_clear: assert property (rd_clr && link_up_in && $past(link_up_in) ##1 sel[15:12] == 4'hD |=> !indicator_out[0])
    else $error("link loss not cleared");
  a_prbs_latch_set: assert property (prbs_error_in ##1 sel[11:8] == 4'hE |=> indicator_out[1])
    else $error("test pattern error not latched");
  // main scenarios reached
  c_lost_read: cover property (rd_clr ##1 sel[15:12] == 4'hD);
  c_prbs_sel: cover property (prbs_error_in ##1 sel[11:8] == 4'hE);
  c_link_fall: cover property ($fell(link_up_in));
endmodule : pmc_regs_asserts

// [verif/pmc_status_model.sv]
// model of the phy status sources feeding the indicators
`timescale 1ns/1ns
module pmc_status_model (
  // clock and wanted levels
  input  wire logic       core_clk_in,
  input  wire logic [9:0] want_in,
  // status lines, bit 0 is link
  output logic      [9:0] status_out
);
  // levels move just after the edge, as the phy core does
  initial status_out = 10'h0A5;
  always @(posedge core_clk_in) begin
    status_out <= want_in;
  end
endmodule : pmc_status_model

// [verif/tb_top.sv]
// self-checking bench for the misc config registers
`timescale 1ns/1ns
module tb_top;
  import pmc_pkg::*;
  logic core_clk_in, reset_in, wr_in, rd_in, short_gap_select_out, host_io_slew_select_out;
  logic [15:0] addr_in, wdata_in, rdata_out, line_driver_prog_out;
  logic [9:0] want, st, tenbase_rx_gain_mv_out; // wanted and actual status
  logic [4:0] tenbase_rx_gain_code_out;
  logic [7:0] gap_cycles_out;
  logic [2:0] indicator_out;
  wire logic clk_en_in = 1'b1;       // always running
  wire logic [10:0] strap_in = 11'h5A3; // fixed strap levels
  int n_mismatch;                     // failed compares
  int checks;                         // compares made
  pmc_misc_config_regs #(.BLINK_DIV(4)) i_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .strap_in(strap_in),
    .tenbase_rx_gain_code_out(tenbase_rx_gain_code_out),
    .tenbase_rx_gain_mv_out(tenbase_rx_gain_mv_out),
    .short_gap_select_out(short_gap_select_out), .gap_cycles_out(gap_cycles_out),
    .host_io_slew_select_out(host_io_slew_select_out),
    .line_driver_prog_out(line_driver_prog_out), .indicator_out(indicator_out),
    .link_up_in(st[0]), .tx_act_in(st[1]), .rx_act_in(st[2]), .collision_in(st[3]),
    .speed_100_in(st[4]), .full_duplex_in(st[5]), .low_power_in(st[6]),
    .mii_error_in(st[7]), .prbs_error_in(st[8]), .prbs_clear_in(st[9]));
  pmc_status_model i_src (.core_clk_in(core_clk_in), .want_in(want), .status_out(st));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : wait_n
  // one-cycle write, strobe dropped at the next edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask : rd
  task automatic st_set(input logic [9:0] v);
    @(posedge core_clk_in);
    want <= v;
    wait_n(4);
  endtask : st_set
  // expected indicator level for a source code
  function automatic logic exp_src(input logic [3:0] c, input logic [9:0] s);
    case (c)
      4'h0: return s[0];
      4'h1, 4'h9: return s[1] | s[2];
      4'h2: return s[1];
      4'h3: return s[2];
      4'h4: return s[3];
      4'h5: return s[4];
      4'h6: return !s[4];
      4'h7: return s[5];
      4'hA: return s[0] & s[4] & s[5];
      4'hB: return s[6];
      4'hC: return s[7];
      default: return 1'b0;
    endcase
  endfunction : exp_src
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {wr_in, rd_in, addr_in, wdata_in, want} = '0;
    want = 10'h0A5;
    reset_in = 1'b1;
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(OFS_LINE_DRIVER, 16'h0080);
    rd(OFS_RX_GAIN, 16'h0000);
    rd(OFS_GENERAL, 16'h0008);
    rd(OFS_INDICATOR, 16'h5665);
    rd(OFS_IO_CONTROL, 16'h0010);
    chk(gap_cycles_out, 8'h03);
    chk(host_io_slew_select_out, 1'b0);
    chk(line_driver_prog_out, 16'h0080);
    wr(OFS_STRAP_STATUS, 16'h0000);
    rd(OFS_STRAP_STATUS, {5'h00, strap_in});
    rd(16'h0400, 16'h0000);
    $display("test reset values done");
    for (int k = 0; k < 32; k++) begin
      wr(OFS_RX_GAIN, 16'(k));
      wait_n(1); // outputs are a registered copy, one cycle behind
      chk(tenbase_rx_gain_mv_out, k > 15 ? 10'h23F : 10'h0C8 + 10'h019 * 10'(k));
      chk(tenbase_rx_gain_code_out, 16'(k[4:0]));
    end
    rd(OFS_RX_GAIN, 16'h001F);
    wr(OFS_GENERAL, 16'h0000);
    wait_n(1);
    chk(gap_cycles_out, 8'h04);
    chk(short_gap_select_out, 1'b0);
    rd(OFS_GENERAL, 16'h0000);
    wr(OFS_GENERAL, 16'h0008);
    wr(OFS_IO_CONTROL, 16'h0011);
    wait_n(1);
    chk(host_io_slew_select_out, 1'b1);
    wr(OFS_IO_CONTROL, 16'h0010);
    wait_n(1);
    chk(host_io_slew_select_out, 1'b0);
    // link-with-blink code: steady on while linked and quiet
    st_set(10'h001);
    wr(OFS_INDICATOR, 16'h8885);
    wait_n(6);
    chk(indicator_out, 3'b111);
    $display("test settings done");
    for (int p = 0; p < 2; p++) begin
      st_set(p ? 10'h05A : 10'h0A5);
      for (int c = 0; c < 16; c++) begin
        if (c == 8 || c == 13 || c == 14) continue;
        wr(OFS_INDICATOR, {c[3:0], c[3:0], c[3:0], 4'h5});
        wait_n(2);
        chk(indicator_out, {3{exp_src(c[3:0], want)}});
      end
    end
    $display("test source codes done");
    // latch may hold an old loss, so clear it first
    st_set(10'h0A5);
    wr(OFS_INDICATOR, 16'hD665);
    rd(OFS_BASIC_STATUS, 16'h0000);
    wait_n(2);
    chk(indicator_out[0], 1'b0);
    st_set(10'h0A4);
    chk(indicator_out[0], 1'b1);
    st_set(10'h0A5);
    chk(indicator_out[0], 1'b1);
    rd(OFS_BASIC_STATUS, 16'h0000);
    wait_n(2);
    chk(indicator_out[0], 1'b0);
    wr(OFS_INDICATOR, 16'h5E65);
    wait_n(2);
    chk(indicator_out[1], 1'b0);
    @(posedge core_clk_in);
    want <= 10'h1A5;
    st_set(10'h0A5);
    wait_n(6);
    chk(indicator_out[1], 1'b1);
    @(posedge core_clk_in);
    want <= 10'h2A5;
    st_set(10'h0A5);
    chk(indicator_out[1], 1'b0);
    $display("test latches done");
    end_of_test();
  end
endmodule : tb_top
bind pmc_misc_config_regs pmc_regs_asserts i_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .link_up_in(link_up_in), .collision_in(collision_in), .speed_100_in(speed_100_in),
  .prbs_error_in(prbs_error_in),
  .tenbase_rx_gain_code_out(tenbase_rx_gain_code_out),
  .tenbase_rx_gain_mv_out(tenbase_rx_gain_mv_out),
  .short_gap_select_out(short_gap_select_out), .gap_cycles_out(gap_cycles_out),
  .indicator_out(indicator_out));
